// File: i2c_to_pkg.sv
/*
  Shared constants of the I2C slave with bus time-out: register offsets, field positions,
  reset values, bus answers, slave states and the time-out clock figures.
  Assumes a 20 MHz core clock and a low-speed RC clock of nominal frequency below.
*/
`default_nettype none
package i2c_to_pkg;
  localparam int CORE_HZ = 20_000_000;
  localparam int LOW_SPEED_RC_CLOCK_HZ = 32_000;
  localparam int TO_PRESCALE = 32;
  localparam int TO_TICK_CYCLES = (CORE_HZ / LOW_SPEED_RC_CLOCK_HZ) * TO_PRESCALE;
  localparam int TO_SETTINGS = 64;

  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_OWN = 5'h04;
  localparam logic [4:0] OFS_CTL0 = 5'h08;
  localparam logic [4:0] OFS_SC1 = 5'h0C;
  localparam logic [4:0] OFS_TOC = 5'h10;

  localparam int CTL0_EN = 0;
  localparam logic [7:0] CTL0_POR = 8'h00;

  localparam int SC1_COMPLETE = 7;
  localparam int SC1_MATCH = 6;
  localparam int SC1_BUSY = 5;
  localparam int SC1_TXDIR = 4;
  localparam int SC1_TXACK = 3;
  localparam int SC1_READREQ = 2;
  localparam int SC1_SPARE = 1;
  localparam int SC1_RXACK = 0;
  localparam logic [7:0] SC1_POR = 8'h81;

  localparam int TOC_EN = 7;
  localparam int TOC_FLAG = 6;
  localparam logic [7:0] TOC_POR = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_HOLD, S_DATA, S_DACK, S_WAIT
  } slv_state_e;
endpackage
`default_nettype wire

// File: timeout_if.sv
/*
  Signals between the slave core and its time-out counter.
  Assumes both ends run on the same core clock.
*/
`default_nettype none
interface timeout_if;
  logic start;
  logic sclFall;
  logic stop;
  logic enable;
  logic [5:0] period;
  logic expire;
  modport ctl (output start, sclFall, stop, enable, period, input expire);
  modport unit (input start, sclFall, stop, enable, period, output expire);
endinterface
`default_nettype wire

// File: timeout_counter.sv
/*
  Bus time-out counter: a divider makes the low-speed RC rate divided by 32 as an enable
  pulse, and whole periods of it are counted since the last SCL falling edge.
  Assumes all inputs are already in the core clock domain.
*/
`default_nettype none
module timeout_counter #(
  parameter int TICK_CYCLES = i2c_to_pkg::TO_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Link to the slave core.
  timeout_if.unit bus
);
  generate
    if (TICK_CYCLES < 1 || TICK_CYCLES > 1_000_000) begin : g_bad
      $error("TICK_CYCLES out of range");
    end
  endgenerate

  logic [19:0] pre_r, pre_nxt;
  logic [6:0] ticks_r, ticks_nxt;
  logic run_r, run_nxt;
  logic expire_r, expire_nxt;

  always_comb begin
    pre_nxt = pre_r;
    ticks_nxt = ticks_r;
    run_nxt = run_r;
    expire_nxt = 1'b0;
    if (!bus.enable || bus.stop) begin
      run_nxt = 1'b0;
    end else if (bus.start) begin
      run_nxt = 1'b1;
      pre_nxt = '0;
      ticks_nxt = '0;
    end else if (run_r) begin
      if (bus.sclFall) begin
        pre_nxt = '0;
        ticks_nxt = '0;
      end else if (pre_r == 20'(TICK_CYCLES - 1)) begin
        pre_nxt = '0;
        ticks_nxt = ticks_r + 7'h01;
        // Expiry after (setting + 1) whole slow periods.
        if (ticks_nxt == {1'b0, bus.period} + 7'h01) begin
          expire_nxt = 1'b1;
          run_nxt = 1'b0;
        end
      end else begin
        pre_nxt = pre_r + 20'h00001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pre_r <= '0;
      ticks_r <= '0;
      run_r <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      ticks_r <= ticks_nxt;
      run_r <= run_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign bus.expire = expire_r;
endmodule
`default_nettype wire

// File: i2c_slave_with_timeout.sv
/*
  I2C slave with bus time-out, registers reached over AXI4-Lite.
  Assumes SCL and SDA arrive asynchronously and are open-drain with external pull-ups;
  the far end is an ordinary I2C master.
*/
// Design decisions made here: the address map and the AXI4-Lite slave port.
`default_nettype none
module i2c_slave_with_timeout #(
  parameter int TICK_CYCLES = i2c_to_pkg::TO_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // AXI4-Lite write channels.
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels.
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // I2C pins, open drain.
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Event pulse on the shared I2C vector.
  output logic i2cEvent
);
  timeout_if toBus ();

  timeout_counter #(.TICK_CYCLES(TICK_CYCLES)) u_timeout (
    .core_clk(core_clk),
    .srst(srst),
    .bus(toBus)
  );

  // Pin synchronisers; the third stage only remembers the previous settled level.
  logic [2:0] sclSync_r, sdaSync_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
    end else begin
      sclSync_r <= {sclSync_r[1:0], sclIn};
      sdaSync_r <= {sdaSync_r[1:0], sdaIn};
    end
  end
  logic scl, sda, sclRise, sclFall, startDet, stopDet;
  assign scl = sclSync_r[1];
  assign sda = sdaSync_r[1];
  assign sclRise = scl && !sclSync_r[2];
  assign sclFall = !scl && sclSync_r[2];
  assign startDet = scl && sclSync_r[2] && !sda && sdaSync_r[2];
  assign stopDet = scl && sclSync_r[2] && sda && !sdaSync_r[2];

  // AXI4-Lite slave.
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, awready_r, awready_nxt;
  logic wready_r, wready_nxt, bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt, wLane_r, wLane_nxt;
  logic [4:0] awAddr_r, awAddr_nxt;
  logic [7:0] wData_r, wData_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic doWrite, rdFire;
  logic [7:0] sc1Val, tocVal, dat_r, own_r, ctl0_r;
  logic [5:0] tocPer_r;
  logic tocEn_r, tocFlag_r;

  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == i2c_to_pkg::OFS_DATA) || (a == i2c_to_pkg::OFS_OWN) ||
             (a == i2c_to_pkg::OFS_CTL0) || (a == i2c_to_pkg::OFS_SC1) ||
             (a == i2c_to_pkg::OFS_TOC);
  endfunction

  assign tocVal = {tocEn_r, tocFlag_r, tocPer_r};
  assign rdFire = arvalid && arready_r;

  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wLane_nxt = wLane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    doWrite = 1'b0;
    if (awvalid && awready_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = wdata[7:0];
      wLane_nxt = wstrb[0];
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (awHeld_r && wHeld_r && !bvalid_r) begin
      doWrite = wLane_r && mapped(awAddr_r);
      bvalid_nxt = 1'b1;
      bresp_nxt = mapped(awAddr_r) ? i2c_to_pkg::RESP_OKAY : i2c_to_pkg::RESP_DECERR;
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
    end
    awready_nxt = !awHeld_nxt && !bvalid_nxt;
    wready_nxt = !wHeld_nxt && !bvalid_nxt;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (rdFire) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = mapped(araddr) ? i2c_to_pkg::RESP_OKAY : i2c_to_pkg::RESP_DECERR;
      case (araddr)
        i2c_to_pkg::OFS_DATA: rdata_nxt = {24'h000000, dat_r};
        i2c_to_pkg::OFS_OWN: rdata_nxt = {24'h000000, own_r};
        i2c_to_pkg::OFS_CTL0: rdata_nxt = {24'h000000, ctl0_r};
        i2c_to_pkg::OFS_SC1: rdata_nxt = {24'h000000, sc1Val};
        i2c_to_pkg::OFS_TOC: rdata_nxt = {24'h000000, tocVal};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 5'h00;
      wData_r <= 8'h00;
      wLane_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'h0;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wLane_r <= wLane_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Slave core state and registers.
  i2c_to_pkg::slv_state_e state_r, state_nxt;
  logic [2:0] bitCnt_r, bitCnt_nxt;
  logic [7:0] shift_r, shift_nxt, dat_nxt, own_nxt, ctl0_nxt;
  logic complete_r, complete_nxt, matched_r, matched_nxt, busy_r, busy_nxt;
  logic txDir_r, txDir_nxt, txAck_r, txAck_nxt, readReq_r, readReq_nxt;
  logic spare_r, spare_nxt, rxAck_r, rxAck_nxt;
  logic tocEn_nxt, tocFlag_nxt;
  logic [5:0] tocPer_nxt;
  logic sdaOe_r, sdaOe_nxt, sclOe_r, sclOe_nxt, event_r, event_nxt;
  logic toStart_r, toStart_nxt, toStop_r, toStop_nxt, low_r;
  logic dataWr, dataAcc;

  assign sc1Val = {complete_r, matched_r, busy_r, txDir_r, txAck_r, readReq_r, spare_r, rxAck_r};
  assign dataWr = doWrite && awAddr_r == i2c_to_pkg::OFS_DATA;
  assign dataAcc = dataWr || (rdFire && araddr == i2c_to_pkg::OFS_DATA);

  always_comb begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    dat_nxt = dat_r;
    own_nxt = own_r;
    ctl0_nxt = ctl0_r;
    {complete_nxt, matched_nxt, busy_nxt, txDir_nxt} = sc1Val[7:4];
    {txAck_nxt, readReq_nxt, spare_nxt, rxAck_nxt} = sc1Val[3:0];
    tocEn_nxt = tocEn_r;
    tocFlag_nxt = tocFlag_r;
    tocPer_nxt = tocPer_r;
    sdaOe_nxt = sdaOe_r;
    sclOe_nxt = sclOe_r;
    event_nxt = 1'b0;
    toStart_nxt = 1'b0;
    toStop_nxt = 1'b0;
    if (doWrite) begin
      case (awAddr_r)
        i2c_to_pkg::OFS_DATA: dat_nxt = wData_r;
        i2c_to_pkg::OFS_OWN: own_nxt = wData_r;
        i2c_to_pkg::OFS_CTL0: ctl0_nxt = wData_r;
        i2c_to_pkg::OFS_SC1: begin
          txDir_nxt = wData_r[i2c_to_pkg::SC1_TXDIR];
          txAck_nxt = wData_r[i2c_to_pkg::SC1_TXACK];
          spare_nxt = wData_r[i2c_to_pkg::SC1_SPARE];
        end
        i2c_to_pkg::OFS_TOC: begin
          tocEn_nxt = wData_r[i2c_to_pkg::TOC_EN];
          tocPer_nxt = wData_r[5:0];
          if (!wData_r[i2c_to_pkg::TOC_FLAG]) begin
            tocFlag_nxt = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Releasing the held clock starts the next byte; a sent byte comes from the register.
    if (state_r == i2c_to_pkg::S_HOLD && dataAcc) begin
      sclOe_nxt = 1'b0;
      complete_nxt = 1'b0;
      matched_nxt = 1'b0;
      state_nxt = i2c_to_pkg::S_DATA;
      bitCnt_nxt = 3'h0;
      shift_nxt = dataWr ? wData_r : dat_r;
      sdaOe_nxt = txDir_r && !shift_nxt[7];
    end
    if (startDet) begin
      busy_nxt = 1'b1;
      sdaOe_nxt = 1'b0;
      sclOe_nxt = 1'b0;
      bitCnt_nxt = 3'h0;
      state_nxt = ctl0_r[i2c_to_pkg::CTL0_EN] ? i2c_to_pkg::S_ADDR : i2c_to_pkg::S_WAIT;
    end else if (stopDet) begin
      busy_nxt = 1'b0;
      sdaOe_nxt = 1'b0;
      sclOe_nxt = 1'b0;
      toStop_nxt = 1'b1;
      state_nxt = i2c_to_pkg::S_IDLE;
    end else if (sclRise) begin
      case (state_r)
        i2c_to_pkg::S_ADDR: begin
          shift_nxt = {shift_r[6:0], sda};
          bitCnt_nxt = bitCnt_r + 3'h1;
          if (bitCnt_r == 3'h7) begin
            if (shift_r[6:0] == own_r[7:1]) begin
              readReq_nxt = sda;
              matched_nxt = 1'b1;
              event_nxt = 1'b1;
              toStart_nxt = 1'b1;
              state_nxt = i2c_to_pkg::S_AACK;
            end else begin
              state_nxt = i2c_to_pkg::S_WAIT;
            end
          end
        end
        i2c_to_pkg::S_DATA: begin
          shift_nxt = txDir_r ? shift_r : {shift_r[6:0], sda};
          bitCnt_nxt = bitCnt_r + 3'h1;
          if (bitCnt_r == 3'h7) begin
            complete_nxt = 1'b1;
            event_nxt = 1'b1;
            if (!txDir_r) begin
              dat_nxt = {shift_r[6:0], sda};
            end
            state_nxt = i2c_to_pkg::S_DACK;
          end
        end
        i2c_to_pkg::S_DACK: begin
          if (txDir_r) begin
            rxAck_nxt = sda;
          end
        end
        default: ;
      endcase
    end else if (sclFall) begin
      case (state_r)
        i2c_to_pkg::S_DATA: begin
          if (txDir_r) begin
            shift_nxt = {shift_r[6:0], 1'b0};
            sdaOe_nxt = !shift_r[6];
          end
        end
        i2c_to_pkg::S_AACK, i2c_to_pkg::S_DACK: begin
          if (bitCnt_r == 3'h0) begin
            bitCnt_nxt = 3'h1;
            if (state_r == i2c_to_pkg::S_AACK) begin
              sdaOe_nxt = 1'b1;
            end else begin
              sdaOe_nxt = !txDir_r && !txAck_r;
            end
          end else begin
            sdaOe_nxt = 1'b0;
            if (state_r == i2c_to_pkg::S_DACK && txDir_r && rxAck_r) begin
              state_nxt = i2c_to_pkg::S_WAIT;
            end else begin
              sclOe_nxt = 1'b1;
              state_nxt = i2c_to_pkg::S_HOLD;
            end
          end
        end
        default: ;
      endcase
    end
    // Time-out wins over everything; data, address and control 0 keep their values.
    if (toBus.expire) begin
      {complete_nxt, matched_nxt, busy_nxt, txDir_nxt} = i2c_to_pkg::SC1_POR[7:4];
      {txAck_nxt, readReq_nxt, spare_nxt, rxAck_nxt} = i2c_to_pkg::SC1_POR[3:0];
      tocEn_nxt = 1'b0;
      tocFlag_nxt = 1'b1;
      event_nxt = 1'b1;
      sdaOe_nxt = 1'b0;
      sclOe_nxt = 1'b0;
      bitCnt_nxt = 3'h0;
      state_nxt = i2c_to_pkg::S_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= i2c_to_pkg::S_IDLE;
      bitCnt_r <= 3'h0;
      shift_r <= 8'h00;
      dat_r <= 8'h00;
      own_r <= 8'h00;
      ctl0_r <= i2c_to_pkg::CTL0_POR;
      {complete_r, matched_r, busy_r, txDir_r} <= i2c_to_pkg::SC1_POR[7:4];
      {txAck_r, readReq_r, spare_r, rxAck_r} <= i2c_to_pkg::SC1_POR[3:0];
      {tocEn_r, tocFlag_r, tocPer_r} <= i2c_to_pkg::TOC_POR;
      sdaOe_r <= 1'b0;
      sclOe_r <= 1'b0;
      event_r <= 1'b0;
      toStart_r <= 1'b0;
      toStop_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      dat_r <= dat_nxt;
      own_r <= own_nxt;
      ctl0_r <= ctl0_nxt;
      {complete_r, matched_r, busy_r, txDir_r} <= {complete_nxt, matched_nxt, busy_nxt, txDir_nxt};
      {txAck_r, readReq_r, spare_r, rxAck_r} <= {txAck_nxt, readReq_nxt, spare_nxt, rxAck_nxt};
      {tocEn_r, tocFlag_r, tocPer_r} <= {tocEn_nxt, tocFlag_nxt, tocPer_nxt};
      sdaOe_r <= sdaOe_nxt;
      sclOe_r <= sclOe_nxt;
      event_r <= event_nxt;
      toStart_r <= toStart_nxt;
      toStop_r <= toStop_nxt;
      low_r <= 1'b0;
    end
  end

  // The pins are only ever pulled low, so no START can come from here.
  assign toBus.start = toStart_r;
  assign toBus.sclFall = sclFall;
  assign toBus.stop = toStop_r;
  assign toBus.enable = tocEn_r;
  assign toBus.period = tocPer_r;

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign sclOut = low_r;
  assign sclOe = sclOe_r;
  assign sdaOut = low_r;
  assign sdaOe = sdaOe_r;
  assign i2cEvent = event_r;
endmodule
`default_nettype wire

// File: i2c_master_model.sv
/*
  Behavioural I2C master on the far side of the slave.
  Assumes open-drain lines with pull-ups, so a pull output high forces its line low.
*/
`default_nettype none
module i2c_master_model (
  // Core clock, only to time the result strobe.
  input wire logic clk,
  // Resolved line levels.
  input wire logic scl,
  input wire logic sda,
  // Pull-downs onto the lines.
  output logic sclPull,
  output logic sdaPull,
  // Value seen on the wire.
  output logic [7:0] res,
  output logic resStb
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclPull = 0;
    sdaPull = 0;
    res = 8'h00;
    resStb = 0;
  end
  task automatic note(input logic [7:0] v);
    res = v;
    @(negedge clk) resStb = 1;
    @(negedge clk) resStb = 0;
  endtask
  // SCL is only released here; the slave may keep it low, so the high phase waits for it.
  task automatic bitOut(input logic b);
    sdaPull = !b;
    #150 sclPull = 0;
    wait (scl);
    #150 sclPull = 1;
    #100;
  endtask
  task automatic bitIn(output logic b);
    sdaPull = 0;
    #150 sclPull = 0;
    wait (scl);
    #75 b = sda;
    #75 sclPull = 1;
    #100;
  endtask
  task automatic start();
    sdaPull = 0;
    sclPull = 0;
    #200 sdaPull = 1;
    #200 sclPull = 1;
    #100;
  endtask
  task automatic stop();
    sdaPull = 1;
    #150 sclPull = 0;
    wait (scl);
    #200 sdaPull = 0;
    #200;
  endtask
  task automatic wrByte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(a);
    note({7'h00, a});
  endtask
  task automatic rdByte(input logic ack);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(ack);
    note(d);
  endtask
endmodule
`default_nettype wire

// File: i2c_slave_with_timeout_properties.sv
/*
  Checker on the ports of the I2C slave with time-out.
  Assumes one core clock domain and a synchronous active-high reset.
*/
`default_nettype none
module i2c_slave_with_timeout_properties #(
  parameter int TICK_CYCLES = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Register bus.
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [4:0] awaddr,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [4:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Pins and event.
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic i2cEvent
);
  // Data register accesses open a short window in which SCL may be let go.
  logic [2:0] acc_r;
  logic [2:0] acc_nxt;
  always_comb begin
    acc_nxt = (acc_r != 3'h0) ? acc_r - 3'h1 : 3'h0;
    if (arvalid && arready && araddr == i2c_to_pkg::OFS_DATA) acc_nxt = 3'h7;
    if (awvalid && awready && awaddr == i2c_to_pkg::OFS_DATA) acc_nxt = 3'h7;
  end
  always_ff @(posedge core_clk) begin
    if (srst) acc_r <= 3'h0;
    else acc_r <= acc_nxt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_NO_START: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("SDA pulled low while SCL high");
  AST_DATA_EDGE: assert property ($fell(sdaOe) |-> !sclIn)
    else $error("SDA released while SCL high");
  AST_HOLD_RELEASE: assert property ($fell(sclOe) |-> acc_r != 3'h0 || i2cEvent || $past(i2cEvent))
    else $error("SCL released without a data access");
  AST_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
    else $error("pin output not low");
  AST_EVENT_PULSE: assert property (i2cEvent |=> !i2cEvent)
    else $error("event longer than one cycle");
  AST_READ_LATENCY: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_READ_ONCE: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  AST_WRITE_ONCE: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer repeated");
  AST_RDATA_WIDTH: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  cover property ($rose(sclOe));
  cover property ($rose(sdaOe));
  cover property (i2cEvent);
endmodule
bind i2c_slave_with_timeout i2c_slave_with_timeout_properties #(.TICK_CYCLES(TICK_CYCLES)) props (
  .core_clk(core_clk), .srst(srst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .sclIn(sclIn), .sclOut(sclOut),
  .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .i2cEvent(i2cEvent));
`default_nettype wire

// File: i2c_slave_with_timeout_tb.sv
/*
  Self-checking bench: register tasks and the main sequence note expectations in queues,
  a monitor compares them as results appear.
  Assumes the checker is bound and the master model is compiled alongside.
*/
`default_nettype none
module i2c_slave_with_timeout_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // A short tick keeps the time-out run brief.
  localparam int TK = 8;
  logic core_clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, sclOut, sclOe, sdaOut, sdaOe, i2cEvent;
  logic [1:0] bresp, rresp;
  logic sclPull, sdaPull, resStb;
  logic [7:0] res, b1, b2, lv;
  logic [33:0] ev, mv;
  logic [33:0] rq[$];
  logic [33:0] rm[$];
  logic [7:0] lq[$];
  logic [1:0] bq[$];
  logic [1:0] bv;
  logic lane0 = 1'b1;
  int evCnt = 0;
  wire logic scl = !(sclOe || sclPull);
  wire logic sda = !(sdaOe || sdaPull);
  int errors = 0;
  int checks = 0;
  integer seed = 32'hB7A2ACA1;
`define CHK(n, s, e) begin checks++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
  i2c_slave_with_timeout #(.TICK_CYCLES(TK)) dut (.core_clk(core_clk), .srst(srst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .i2cEvent(i2cEvent));
  i2c_master_model mdl (.clk(core_clk), .scl(scl), .sda(sda), .sclPull(sclPull),
    .sdaPull(sdaPull), .res(res), .resStb(resStb));
  initial begin
    core_clk = 0;
    forever #25 core_clk = !core_clk;
  end
  always @(posedge core_clk) begin
    if (rvalid && rready) begin
      ev = rq.pop_front();
      mv = rm.pop_front();
      `CHK("rdata", {rresp, rdata} & mv, ev)
    end
    if (resStb) begin
      lv = lq.pop_front();
      `CHK("link", res, lv)
    end
    if (bvalid && bready) begin
      bv = bq.pop_front();
      `CHK("bresp", bresp, bv)
    end
    if (i2cEvent) begin
      evCnt++;
    end
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bq.push_back((a inside {i2c_to_pkg::OFS_DATA, i2c_to_pkg::OFS_OWN,
      i2c_to_pkg::OFS_CTL0, i2c_to_pkg::OFS_SC1, i2c_to_pkg::OFS_TOC}) ?
      i2c_to_pkg::RESP_OKAY : i2c_to_pkg::RESP_DECERR);
    awvalid <= 1;
    wvalid <= 1;
    awaddr <= a;
    wdata <= {24'($random(seed)), d};
    wstrb <= (4'($random(seed)) & 4'hE) | {3'h0, lane0};
    bready <= 1'($random(seed));
    fork
      begin
        do @(posedge core_clk); while (!awready);
        awvalid <= 0;
        awaddr <= 5'($random(seed));
      end
      begin
        do @(posedge core_clk); while (!wready);
        wvalid <= 0;
        wdata <= 32'($random(seed));
      end
    join
    bready <= 1;
    do @(posedge core_clk); while (!bvalid);
    bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [1:0] r, input logic [7:0] e,
    input logic [7:0] m);
    @(posedge core_clk);
    rq.push_back({r, 24'h000000, e & m});
    rm.push_back({2'h3, {24{|m}}, m});
    arvalid <= 1;
    araddr <= a;
    rready <= 1'($random(seed));
    do @(posedge core_clk); while (!arready);
    arvalid <= 0;
    araddr <= 5'($random(seed));
    rready <= 1;
    do @(posedge core_clk); while (!rvalid);
    rready <= 0;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
  initial begin
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata, wstrb} = {10'h000, 32'h00000000, 4'hF};
    b1 = 8'($random(seed));
    b2 = 8'($random(seed));
    repeat (5) @(posedge core_clk);
    srst <= 0;
    rd(i2c_to_pkg::OFS_SC1, 2'h0, i2c_to_pkg::SC1_POR, 8'hFF);
    rd(i2c_to_pkg::OFS_TOC, 2'h0, i2c_to_pkg::TOC_POR, 8'hFF);
    rd(5'h14, i2c_to_pkg::RESP_DECERR, 8'h00, 8'h00);
    wr(i2c_to_pkg::OFS_OWN, 8'hB5);
    rd(i2c_to_pkg::OFS_OWN, 2'h0, 8'hB5, 8'hFF);
    // A write without the low byte lane leaves the register alone.
    lane0 = 1'b0;
    wr(i2c_to_pkg::OFS_OWN, 8'h11);
    lane0 = 1'b1;
    rd(i2c_to_pkg::OFS_OWN, 2'h0, 8'hB5, 8'hFF);
    wr(5'h14, 8'h00);
    wr(i2c_to_pkg::OFS_CTL0, 8'h01);
    wr(i2c_to_pkg::OFS_SC1, 8'h00);
    // Master writes two bytes; the second is refused by the acknowledge bit.
    mdl.start();
    rd(i2c_to_pkg::OFS_SC1, 2'h0, 8'h20, 8'h20);
    lq.push_back(8'h00);
    mdl.wrByte(8'hB4);
    rd(i2c_to_pkg::OFS_SC1, 2'h0, 8'h60, 8'h64);
    rd(i2c_to_pkg::OFS_DATA, 2'h0, 8'h00, 8'h00);
    lq.push_back(8'h00);
    mdl.wrByte(b1);
    wr(i2c_to_pkg::OFS_SC1, 8'h08);
    rd(i2c_to_pkg::OFS_SC1, 2'h0, 8'h80, 8'hC0);
    rd(i2c_to_pkg::OFS_DATA, 2'h0, b1, 8'hFF);
    lq.push_back(8'h01);
    mdl.wrByte(b2);
    rd(i2c_to_pkg::OFS_DATA, 2'h0, b2, 8'hFF);
    mdl.stop();
    rd(i2c_to_pkg::OFS_SC1, 2'h0, 8'h00, 8'h20);
    // A foreign address is not acknowledged and the master gives up.
    mdl.start();
    lq.push_back(8'h01);
    mdl.wrByte(8'h66);
    mdl.stop();
    // Master reads two bytes and refuses the second.
    wr(i2c_to_pkg::OFS_SC1, 8'h00);
    mdl.start();
    lq.push_back(8'h00);
    mdl.wrByte(8'hB5);
    rd(i2c_to_pkg::OFS_SC1, 2'h0, 8'h64, 8'h64);
    wr(i2c_to_pkg::OFS_SC1, 8'h10);
    wr(i2c_to_pkg::OFS_DATA, b1);
    lq.push_back(b1);
    mdl.rdByte(1'b0);
    wr(i2c_to_pkg::OFS_DATA, b2);
    lq.push_back(b2);
    mdl.rdByte(1'b1);
    rd(i2c_to_pkg::OFS_SC1, 2'h0, 8'h01, 8'h01);
    mdl.stop();
    // The slave holds SCL after the match and nobody serves it, so the counter runs out.
    wr(i2c_to_pkg::OFS_TOC, 8'h83);
    mdl.start();
    lq.push_back(8'h00);
    mdl.wrByte(8'hB4);
    rd(i2c_to_pkg::OFS_TOC, 2'h0, 8'h83, 8'hFF);
    repeat (4 * TK + 20) @(posedge core_clk);
    rd(i2c_to_pkg::OFS_TOC, 2'h0, 8'h43, 8'hFF);
    rd(i2c_to_pkg::OFS_SC1, 2'h0, i2c_to_pkg::SC1_POR, 8'hFF);
    rd(i2c_to_pkg::OFS_OWN, 2'h0, 8'hB5, 8'hFF);
    wr(i2c_to_pkg::OFS_TOC, 8'h03);
    rd(i2c_to_pkg::OFS_TOC, 2'h0, 8'h03, 8'hFF);
    mdl.stop();
    // With the time-out disabled a stalled hold must outlive the same span.
    mdl.start();
    lq.push_back(8'h00);
    mdl.wrByte(8'hB4);
    repeat (4 * TK + 20) @(posedge core_clk);
    rd(i2c_to_pkg::OFS_TOC, 2'h0, 8'h03, 8'hFF);
    rd(i2c_to_pkg::OFS_SC1, 2'h0, 8'h60, 8'h60);
    rd(i2c_to_pkg::OFS_DATA, 2'h0, 8'h00, 8'h00);
    mdl.stop();
    `CHK("events", evCnt, 9)
    wrap_up();
  end
endmodule
`default_nettype wire
